// ==== design/cmp_sync.sv ====
// Two-stage synchroniser for the raw comparator outputs.
`timescale 1ns/10ps
`default_nettype none

module cmp_sync (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [1:0] raw_in,
	output logic      [1:0] sync_out
);

	logic [1:0] stage_one_reg;

	genvar i;
	generate
		for (i = 0; i < 2; i++) begin : g_sync
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					stage_one_reg[i] <= 1'b0;
					sync_out[i]      <= 1'b0;
				end else begin
					stage_one_reg[i] <= raw_in[i];
					sync_out[i]      <= stage_one_reg[i];
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

// ==== design/comparator_irq_and_vref_control.sv ====
// Comparator change detection, interrupt gating and reference ladder control behind APB.
//
// Contract
// [R01] Either comparator result differing from its last seen copy sets the change flag.
// [R02] Software writing 0 clears the change flag; writing 1 sets it.
// [R03] Change flag is bit 6 of flags two; its enable is bit 6 of enables two.
// [R04] Interrupt only when flag, change enable, peripheral and global enables all set.
// [R05] The flag sets on a change even while any enable is clear.
// [R06] A change coinciding with a control register access may not set the flag.
// [R07] Any read or write of comparator control refreshes the reference copy.
// [R08] A lasting mismatch keeps setting the flag, so clears only stick afterwards.
// [R09] Active comparators keep working in sleep; an enabled change interrupt wakes.
// [R10] Waking from sleep leaves comparator control unchanged.
// [R11] Software should set mode 111 before sleep to save power.
// [R12] Reset puts comparator control in reset state with mode 111, both off.
// [R13] Comparator pins default analog after reset, following the port analog field.
// [R14] Reference power bit 7 powers the ladder on at 1, down at 0.
// [R15] Pin output enable bit 6 drives the reference pin, overriding direction bit 5.
// [R16] Range bit 5: 1 is low range in 1/24 steps, 0 high range in 1/32.
// [R17] Source bit 4: 1 uses external reference pins, 0 the supply rails.
// [R18] Four-bit level code picks one of sixteen taps within the range.
// [R19] Reset clears reference power, pin enable, range and level bits.
// [R20] Result bits 7 and 6 read 1 when plus exceeds minus, inverted if set.
// [R21] Internal reference feeds both positive inputs only in mode 110.
// [R22] Results are synchronised and compared with a copy refreshed on each access.
`timescale 1ns/10ps
`default_nettype none
`include "cmp_params.svh"

module comparator_irq_and_vref_control (
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [`CMP_ADDR_W-1:0] paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire logic                   cmp_one_raw,
	input  wire logic                   cmp_two_raw,
	input  wire logic                   sleep_active,
	output logic                        irq_req,
	output logic                        irq_high_priority,
	output logic                        wake_req,
	output logic                        cmp_one_out,
	output logic                        cmp_two_out,
	output logic      [2:0]             cmp_mode,
	output logic                        cmp_input_switch,
	output logic                        cmp_enabled,
	output logic                        ref_to_positive_inputs,
	output logic      [3:0]             port_analog_config,
	output logic      [1:0]             ref_voltage_config,
	output logic                        ladder_power,
	output logic                        ladder_range_low,
	output logic                        ladder_source_ext,
	output logic      [3:0]             ladder_level_code,
	output logic      [6:0]             ladder_tap_96ths,
	output logic                        ref_pin_drive,
	output logic                        port_f5_oe_n
);

	logic [7:0]            intctl_reg;
	logic [7:0]            flags2_reg;
	logic [7:0]            enables2_reg;
	logic [7:0]            priority2_reg;
	cmp_pkg::cmp_ctrl_s    cmpctl_reg;
	cmp_pkg::ladder_ctrl_s ladder_reg;
	logic [7:0]            conv1_reg;
	logic [7:0]            portf_dir_reg;
	logic [1:0]            seen_reg;
	logic [31:0]           prdata_reg;
	logic                  slverr_reg;

	logic [1:0]            cmp_sync_q;
	logic [1:0]            result_now;
	logic                  mismatch;
	logic                  setup_phase;
	logic                  access_done;
	logic                  wr_done;
	logic                  cmpctl_touch;
	logic [7:0]            rd_byte;
	logic                  irq_gate;

	// Decodes a register offset; used only for the error flag, the read mux decodes on its own.
	function automatic logic is_mapped(input logic [`CMP_ADDR_W-1:0] a);
		unique case (a)
			`CMP_OFF_INTCTL, `CMP_OFF_FLAGS2, `CMP_OFF_ENABLES2, `CMP_OFF_PRIORITY2,
			`CMP_OFF_CMPCTL, `CMP_OFF_LADDER, `CMP_OFF_CONV1, `CMP_OFF_PORTF_DIR:
				is_mapped = 1'b1;
			default:
				is_mapped = 1'b0;
		endcase
	endfunction

	cmp_sync u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.raw_in   ({cmp_two_raw, cmp_one_raw}),
		.sync_out (cmp_sync_q)
	); // [R22]

	ladder_tap u_tap (
		.pclk      (pclk),
		.presetn   (presetn),
		.ctrl      (ladder_reg),
		.tap_96ths (ladder_tap_96ths),
		.ladder_on (ladder_power)
	);

	// Switched-off comparators report a steady low so that raw input changes cannot
	// set the change flag while they stay off.
	always_comb begin
		if (cmpctl_reg.mode == `CMP_MODE_OFF) begin
			result_now = 2'b00;
		end else begin
			result_now = cmp_sync_q ^ {cmpctl_reg.inv_two, cmpctl_reg.inv_one}; // [R20]
		end
	end

	assign mismatch = (result_now != seen_reg); // [R01] [R22]

	// Bus timing: read data are captured at the setup edge, so every access has one
	// access cycle and pready is simply the access phase.
	assign setup_phase  = psel & ~penable;
	assign pready       = psel & penable;
	assign access_done  = psel & penable;
	assign wr_done      = access_done & pwrite;
	assign cmpctl_touch = access_done & (paddr == `CMP_OFF_CMPCTL); // [R07]
	assign prdata       = prdata_reg;
	assign pslverr      = slverr_reg & pready;

	always_comb begin
		unique case (paddr)
			`CMP_OFF_INTCTL:    rd_byte = intctl_reg;
			`CMP_OFF_FLAGS2:    rd_byte = flags2_reg;
			`CMP_OFF_ENABLES2:  rd_byte = enables2_reg;
			`CMP_OFF_PRIORITY2: rd_byte = priority2_reg;
			`CMP_OFF_CMPCTL:    rd_byte = {result_now, cmpctl_reg[5:0]}; // [R20]
			`CMP_OFF_LADDER:    rd_byte = ladder_reg;
			`CMP_OFF_CONV1:     rd_byte = conv1_reg;
			`CMP_OFF_PORTF_DIR: rd_byte = portf_dir_reg;
			default:            rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h00000000;
			slverr_reg <= 1'b0;
		end else if (setup_phase) begin
			prdata_reg <= {24'h000000, rd_byte};
			slverr_reg <= ~is_mapped(paddr);
		end
	end

	// Reference copy of the results; only a control register access updates it. A
	// change landing in that very cycle still sets the flag once, which is allowed.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seen_reg <= 2'b00;
		end else if (cmpctl_touch) begin
			seen_reg <= result_now; // [R07] [R06] [R22]
		end
	end

	// Flags two: the hardware set outranks a software clear in the same cycle, and
	// a standing mismatch sets it again on every cycle until the copy is refreshed.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags2_reg <= `CMP_RST_FLAGS2;
		end else begin
			if (wr_done && paddr == `CMP_OFF_FLAGS2) begin
				flags2_reg <= pwdata[7:0] & `CMP_FLAGS2_MASK; // [R02]
			end
			if (mismatch) begin
				flags2_reg[`CMP_BIT_CHANGE] <= 1'b1; // [R01] [R03] [R05] [R08]
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			intctl_reg <= `CMP_RST_INTCTL;
		end else if (wr_done && paddr == `CMP_OFF_INTCTL) begin
			intctl_reg <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enables2_reg <= `CMP_RST_ENABLES2;
		end else if (wr_done && paddr == `CMP_OFF_ENABLES2) begin
			enables2_reg <= pwdata[7:0] & `CMP_FLAGS2_MASK; // [R03]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			priority2_reg <= `CMP_RST_PRIORITY2;
		end else if (wr_done && paddr == `CMP_OFF_PRIORITY2) begin
			priority2_reg <= pwdata[7:0] & `CMP_FLAGS2_MASK;
		end
	end

	// Comparator control holds no sleep dependence at all, so a wake-up leaves it
	// exactly as software left it.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmpctl_reg <= `CMP_RST_CMPCTL; // [R12]
		end else if (wr_done && paddr == `CMP_OFF_CMPCTL) begin
			cmpctl_reg <= pwdata[7:0] & `CMP_CMPCTL_WMASK; // [R10]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ladder_reg <= `CMP_RST_LADDER; // [R19]
		end else if (wr_done && paddr == `CMP_OFF_LADDER) begin
			ladder_reg <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conv1_reg <= `CMP_RST_CONV1; // [R13]
		end else if (wr_done && paddr == `CMP_OFF_CONV1) begin
			conv1_reg <= pwdata[7:0] & `CMP_CONV1_MASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			portf_dir_reg <= `CMP_RST_PORTF_DIR;
		end else if (wr_done && paddr == `CMP_OFF_PORTF_DIR) begin
			portf_dir_reg <= pwdata[7:0] & `CMP_PORTF_MASK;
		end
	end

	assign irq_gate = flags2_reg[`CMP_BIT_CHANGE] & enables2_reg[`CMP_BIT_CHANGE]
		& intctl_reg[`CMP_BIT_PERIPHERAL_IRQ_ENABLE] & intctl_reg[`CMP_BIT_GIE]; // [R04]

	// Registered outputs; the sleep input does not stop any of this logic.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_req           <= 1'b0;
			irq_high_priority <= 1'b0;
			wake_req          <= 1'b0;
		end else begin
			irq_req           <= irq_gate; // [R04]
			irq_high_priority <= irq_gate & priority2_reg[`CMP_BIT_CHANGE];
			wake_req          <= irq_gate & sleep_active; // [R09]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_one_out            <= 1'b0;
			cmp_two_out            <= 1'b0;
			cmp_mode               <= `CMP_MODE_OFF; // [R12]
			cmp_input_switch       <= 1'b0;
			cmp_enabled            <= 1'b0;
			ref_to_positive_inputs <= 1'b0;
		end else begin
			cmp_one_out            <= result_now[0]; // [R20]
			cmp_two_out            <= result_now[1]; // [R20]
			cmp_mode               <= cmpctl_reg.mode;
			cmp_input_switch       <= cmpctl_reg.input_switch;
			cmp_enabled            <= (cmpctl_reg.mode != `CMP_MODE_OFF); // [R09] [R12]
			ref_to_positive_inputs <= (cmpctl_reg.mode == `CMP_MODE_MUX_REF); // [R21]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_analog_config <= 4'h0;
			ref_voltage_config <= 2'h0;
		end else begin
			port_analog_config <= conv1_reg[3:0]; // [R13]
			ref_voltage_config <= conv1_reg[5:4];
		end
	end

	// The reference pin is forced to output while the ladder drives it, whatever its
	// direction bit says; the direction bit only matters again once that is off.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ladder_range_low  <= 1'b0;
			ladder_source_ext <= 1'b0;
			ladder_level_code <= 4'h0;
			ref_pin_drive     <= 1'b0;
			port_f5_oe_n      <= 1'b1;
		end else begin
			ladder_range_low  <= ladder_reg.range_low; // [R16]
			ladder_source_ext <= ladder_reg.src_ext; // [R17]
			ladder_level_code <= ladder_reg.level; // [R18]
			ref_pin_drive     <= ladder_reg.pin_oe; // [R15]
			port_f5_oe_n      <= ~(ladder_reg.pin_oe | ~portf_dir_reg[`CMP_BIT_PORTF_REF]); // [R15]
		end
	end

endmodule

`default_nettype wire

// ==== design/ladder_tap.sv ====
// Ladder tap selection: reference level in 96ths of the source span.
`timescale 1ns/10ps
`default_nettype none
`include "cmp_params.svh"

module ladder_tap (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire cmp_pkg::ladder_ctrl_s ctrl,
	output logic               [6:0]  tap_96ths,
	output logic                      ladder_on
);

	logic [6:0] tap_next;

	// Low range steps by 1/24 (4/96); high range starts at 1/4 and steps by 1/32 (3/96).
	always_comb begin
		if (ctrl.range_low) begin
			tap_next = 7'(ctrl.level) * 7'(`CMP_TAP_STEP_LOW); // [R16] [R18]
		end else begin
			tap_next = 7'(`CMP_TAP_QUARTER + ctrl.level * `CMP_TAP_STEP_HIGH); // [R16] [R18]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tap_96ths <= 7'h00;
			ladder_on <= 1'b0;
		end else begin
			tap_96ths <= tap_next;
			ladder_on <= ctrl.power; // [R14]
		end
	end

endmodule

`default_nettype wire

// ==== shared/cmp_params.svh ====
// Register offsets, field positions and reset values of the comparator control block.
`ifndef CMP_PARAMS_SVH
`define CMP_PARAMS_SVH

`define CMP_ADDR_W            12
`define CMP_OFF_INTCTL        12'h000
`define CMP_OFF_FLAGS2        12'h004
`define CMP_OFF_ENABLES2      12'h008
`define CMP_OFF_PRIORITY2     12'h00C
`define CMP_OFF_CMPCTL        12'h010
`define CMP_OFF_LADDER        12'h014
`define CMP_OFF_CONV1         12'h018
`define CMP_OFF_PORTF_DIR     12'h01C

`define CMP_BIT_GIE           7
`define CMP_BIT_PERIPHERAL_IRQ_ENABLE          6
`define CMP_BIT_CHANGE        6
`define CMP_BIT_RES_TWO       7
`define CMP_BIT_RES_ONE       6
`define CMP_BIT_INV_TWO       5
`define CMP_BIT_INV_ONE       4
`define CMP_BIT_PORTF_REF     5

`define CMP_FLAGS2_MASK       8'hCE
`define CMP_CMPCTL_WMASK      8'h3F
`define CMP_CONV1_MASK        8'h3F
`define CMP_PORTF_MASK        8'hFE

`define CMP_RST_INTCTL        8'h00
`define CMP_RST_FLAGS2        8'h00
`define CMP_RST_ENABLES2      8'h00
`define CMP_RST_PRIORITY2     8'hCE
`define CMP_RST_CMPCTL        8'h07
`define CMP_RST_LADDER        8'h00
`define CMP_RST_CONV1         8'h00
`define CMP_RST_PORTF_DIR     8'hFE

`define CMP_MODE_OFF          3'h7
`define CMP_MODE_MUX_REF      3'h6

`define CMP_TAP_QUARTER       7'h18
`define CMP_TAP_STEP_LOW      3'h4
`define CMP_TAP_STEP_HIGH     3'h3

`endif

// ==== shared/cmp_pkg.sv ====
// Types shared by the comparator control block.
package cmp_pkg;

	typedef struct packed {
		logic       power;
		logic       pin_oe;
		logic       range_low;
		logic       src_ext;
		logic [3:0] level;
	} ladder_ctrl_s;

	typedef struct packed {
		logic       res_two;
		logic       res_one;
		logic       inv_two;
		logic       inv_one;
		logic       input_switch;
		logic [2:0] mode;
	} cmp_ctrl_s;

endpackage

// ==== verif/cmp_ctrl_chk.sv ====
// Port-level checker for the comparator control block, bound to its top module.
`timescale 1ns/10ps
`default_nettype none

module cmp_ctrl_chk (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       sleep_active,
	input wire logic       irq_req,
	input wire logic       irq_high_priority,
	input wire logic       wake_req,
	input wire logic       cmp_one_out,
	input wire logic       cmp_two_out,
	input wire logic [2:0] cmp_mode,
	input wire logic       cmp_enabled,
	input wire logic       ref_to_positive_inputs,
	input wire logic       ladder_power,
	input wire logic       ladder_range_low,
	input wire logic [3:0] ladder_level_code,
	input wire logic [6:0] ladder_tap_96ths,
	input wire logic       ref_pin_drive,
	input wire logic       port_f5_oe_n
);
	logic [6:0] tap_exp;

	// Low range counts in 96ths by fours, high range starts at a quarter and steps by threes.
	assign tap_exp = ladder_range_low ? {1'b0, ladder_level_code, 2'b00}
		: 7'h18 + {3'h0, ladder_level_code} * 7'h03;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_wake;
		wake_req == (irq_req && $past(sleep_active));
	endproperty
	a_wake: assert property (p_wake) else $error("wake request differs from gated irq");

	property p_prio;
		irq_high_priority |-> irq_req;
	endproperty
	a_prio: assert property (p_prio) else $error("high priority without irq");

	property p_enabled;
		cmp_enabled == (cmp_mode != 3'h7);
	endproperty
	a_enabled: assert property (p_enabled) else $error("enable differs from mode");

	property p_refpos;
		ref_to_positive_inputs == (cmp_mode == 3'h6);
	endproperty
	a_refpos: assert property (p_refpos) else $error("reference routing differs from mode");

	property p_refon;
		ref_to_positive_inputs |-> cmp_enabled;
	endproperty
	a_refon: assert property (p_refon) else $error("reference routed while off");

	property p_oe;
		ref_pin_drive |-> !port_f5_oe_n;
	endproperty
	a_oe: assert property (p_oe) else $error("reference pin not driven");

	property p_off;
		cmp_mode == 3'h7 && $past(cmp_mode) == 3'h7 |-> !cmp_one_out && !cmp_two_out;
	endproperty
	a_off: assert property (p_off) else $error("result high while comparators off");

	// Tap and its control outputs change on the same edge; the power guard skips
	// the reset value of the tap, which does not follow the formula.
	property p_tap;
		ladder_power |-> ladder_tap_96ths == tap_exp;
	endproperty
	a_tap: assert property (p_tap) else $error("ladder tap wrong for code and range");
endmodule

bind comparator_irq_and_vref_control cmp_ctrl_chk u_cmp_ctrl_chk (
	.pclk, .presetn, .sleep_active, .irq_req, .irq_high_priority, .wake_req,
	.cmp_one_out, .cmp_two_out, .cmp_mode, .cmp_enabled, .ref_to_positive_inputs,
	.ladder_power, .ladder_range_low, .ladder_level_code, .ladder_tap_96ths,
	.ref_pin_drive, .port_f5_oe_n
);

`default_nettype wire

// ==== verif/comparator_irq_and_vref_control_tb.sv ====
// Self-checking bench for the comparator control block driven over APB.
`timescale 1ns/10ps
`default_nettype none
`include "cmp_params.svh"

module comparator_irq_and_vref_control_tb;
	logic                   pclk = 1'b0;
	logic                   presetn = 1'b0;
	logic                   psel = 1'b0;
	logic                   penable = 1'b0;
	logic                   pwrite = 1'b0;
	logic [`CMP_ADDR_W-1:0] paddr = 12'h000;
	logic [31:0]            pwdata = 32'h0;
	logic                   cmp_one_raw = 1'b0;
	logic                   cmp_two_raw = 1'b0;
	logic                   sleep_active = 1'b0;
	logic [31:0]            prdata;
	logic [31:0]            rd;
	logic                   pready, pslverr, err, irq_req, irq_high_priority, wake_req;
	logic                   cmp_one_out, cmp_two_out, cmp_input_switch, cmp_enabled;
	logic                   ref_to_positive_inputs, ladder_power, ladder_range_low;
	logic                   ladder_source_ext, ref_pin_drive, port_f5_oe_n;
	logic [2:0]             cmp_mode;
	logic [3:0]             port_analog_config, ladder_level_code;
	logic [1:0]             ref_voltage_config;
	logic [6:0]             ladder_tap_96ths;
	int                     n_fail = 0;
	int                     checks = 0;
	int                     cycles = 0;
	logic [7:0]             rst_val [8] = '{8'h00, 8'h00, 8'h00, 8'hCE, 8'h07, 8'h00, 8'h00, 8'hFE};
	logic [7:0]             lad [4] = '{8'hBF, 8'hC0, 8'h8F, 8'h65};

	comparator_irq_and_vref_control u_comparator_irq_and_vref_control (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .cmp_one_raw, .cmp_two_raw, .sleep_active, .irq_req, .irq_high_priority,
		.wake_req, .cmp_one_out, .cmp_two_out, .cmp_mode, .cmp_input_switch, .cmp_enabled,
		.ref_to_positive_inputs, .port_analog_config, .ref_voltage_config, .ladder_power,
		.ladder_range_low, .ladder_source_ext, .ladder_level_code, .ladder_tap_96ths,
		.ref_pin_drive, .port_f5_oe_n
	);

	always #50 pclk = ~pclk;

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	always @(posedge pclk) begin
		cycles++;
		if (cycles == 3000) begin
			n_fail++;
			tally_and_finish();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// The request is held until pready is seen high, so no wait-state count is assumed.
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		check(rd, exp);
	endtask

	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			rd_chk(12'(i * 4), {24'h0, rst_val[i]});
		end
		check(32'({cmp_mode, port_f5_oe_n, ladder_power, port_analog_config}), 32'h1E0);
		xfer(1'b1, 12'h020, 32'hFF);
		rd_chk(12'h020, 32'h0);
		check(32'(err), 32'h1);
		xfer(1'b1, `CMP_OFF_CONV1, 32'hFF);
		rd_chk(`CMP_OFF_CONV1, 32'h3F);
		check(32'({ref_voltage_config, port_analog_config}), 32'h3F);
		$display("test reset and map done");
		for (int i = 0; i < 4; i++) begin
			xfer(1'b1, `CMP_OFF_LADDER, {24'h0, lad[i]});
			rd_chk(`CMP_OFF_LADDER, {24'h0, lad[i]});
			check(32'({ladder_power, ref_pin_drive, ladder_range_low, ladder_source_ext,
				ladder_level_code}), {24'h0, lad[i]});
			check(32'(ladder_tap_96ths), lad[i][5] ? 32'(lad[i][3:0]) * 32'h4
				: 32'h18 + 32'(lad[i][3:0]) * 32'h3);
			check(32'(port_f5_oe_n), 32'(!lad[i][6]));
		end
		xfer(1'b1, `CMP_OFF_LADDER, 32'h0);
		xfer(1'b1, `CMP_OFF_PORTF_DIR, 32'hDF);
		rd_chk(`CMP_OFF_PORTF_DIR, 32'hDE);
		check(32'({ref_pin_drive, port_f5_oe_n}), 32'h0);
		$display("test ladder done");
		for (int m = 0; m < 8; m++) begin
			xfer(1'b1, `CMP_OFF_CMPCTL, 32'({m[0], 3'(m)}));
			repeat (3) @(posedge pclk);
			check(32'({cmp_mode, cmp_input_switch, cmp_enabled, ref_to_positive_inputs}),
				32'({3'(m), m[0], m != 7, m == 6}));
		end
		cmp_one_raw <= 1'b1;
		repeat (6) @(posedge pclk);
		rd_chk(`CMP_OFF_CMPCTL, 32'h0F);
		cmp_one_raw <= 1'b0;
		xfer(1'b1, `CMP_OFF_CMPCTL, 32'h00);
		xfer(1'b1, `CMP_OFF_ENABLES2, 32'h40);
		xfer(1'b1, `CMP_OFF_INTCTL, 32'hC0);
		xfer(1'b1, `CMP_OFF_FLAGS2, 32'h00);
		rd_chk(`CMP_OFF_FLAGS2, 32'h00);
		$display("test modes done");
		cmp_one_raw <= 1'b1;
		repeat (6) @(posedge pclk);
		rd_chk(`CMP_OFF_FLAGS2, 32'h40);
		check(32'({irq_req, irq_high_priority, wake_req, cmp_one_out}), 32'hD);
		xfer(1'b1, `CMP_OFF_FLAGS2, 32'h00);
		rd_chk(`CMP_OFF_FLAGS2, 32'h40);
		rd_chk(`CMP_OFF_CMPCTL, 32'h40);
		xfer(1'b1, `CMP_OFF_FLAGS2, 32'h00);
		rd_chk(`CMP_OFF_FLAGS2, 32'h00);
		check(32'(irq_req), 32'h0);
		sleep_active <= 1'b1;
		cmp_two_raw <= 1'b1;
		repeat (6) @(posedge pclk);
		check(32'(wake_req), 32'h1);
		sleep_active <= 1'b0;
		rd_chk(`CMP_OFF_CMPCTL, 32'hC0);
		xfer(1'b1, `CMP_OFF_FLAGS2, 32'h00);
		xfer(1'b1, `CMP_OFF_INTCTL, 32'h40);
		cmp_one_raw <= 1'b0;
		repeat (6) @(posedge pclk);
		rd_chk(`CMP_OFF_FLAGS2, 32'h40);
		check(32'(irq_req), 32'h0);
		xfer(1'b1, `CMP_OFF_INTCTL, 32'hC0);
		repeat (3) @(posedge pclk);
		check(32'(irq_req), 32'h1);
		rd_chk(`CMP_OFF_CMPCTL, 32'h80);
		xfer(1'b1, `CMP_OFF_FLAGS2, 32'h00);
		xfer(1'b1, `CMP_OFF_FLAGS2, 32'h40);
		rd_chk(`CMP_OFF_FLAGS2, 32'h40);
		check(32'(irq_req), 32'h1);
		xfer(1'b1, `CMP_OFF_CMPCTL, 32'h30);
		repeat (6) @(posedge pclk);
		rd_chk(`CMP_OFF_CMPCTL, 32'h70);
		check(32'({cmp_one_out, cmp_two_out}), 32'h2);
		$display("test change flag done");
		xfer(1'b1, `CMP_OFF_CMPCTL, 32'h07);
		rd_chk(`CMP_OFF_CMPCTL, 32'h07);
		xfer(1'b1, `CMP_OFF_FLAGS2, 32'h00);
		sleep_active <= 1'b1;
		cmp_one_raw <= 1'b1;
		repeat (6) @(posedge pclk);
		rd_chk(`CMP_OFF_FLAGS2, 32'h00);
		check(32'({wake_req, cmp_enabled}), 32'h0);
		$display("test sleep with comparators off done");
		tally_and_finish();
	end
endmodule

`default_nettype wire
